// ===== verilog/spc_pkg.sv
// Purpose: Constants for the strap configuration loader
// Assumes: Straps are static board levels, synchronous to i_clock
// Notes: Register images are the parallel-mode register contents
package spc_pkg;
	// ****************************************************************
	// Register image fields
	// ****************************************************************
	localparam int SPC_ENABLE_BIT = 6;
	localparam int SPC_SEL_LSB = 0;
	localparam int SPC_PE_LSB = 2;
	localparam int SPC_OTO_BIT = 1;
	localparam int SPC_OCL_BIT = 0;
	localparam logic [7:0] SPC_REG_ZERO = 8'h00;
	localparam logic [7:0] SPC_REG_ONES = 8'hFF;
	localparam logic [7:0] SPC_AUX_MODE_FIXED = 8'h40;
	// ****************************************************************
	// Source codes
	// ****************************************************************
	localparam logic [1:0] SPC_SRC_A = 2'h0;
	localparam logic [1:0] SPC_SRC_B = 2'h1;
	localparam logic [1:0] SPC_SRC_C = 2'h2;
	localparam logic [1:0] SPC_SRC_D = 2'h3;
	localparam logic [3:0] SPC_ONEHOT_A = 4'h1;
	localparam logic [3:0] SPC_ONEHOT_B = 4'h2;
	localparam logic [3:0] SPC_ONEHOT_C = 4'h4;
	localparam logic [3:0] SPC_ONEHOT_D = 4'h8;
	localparam int SPC_LANES = 4;
	// ****************************************************************
	// Loader states
	// ****************************************************************
	typedef enum logic [2:0]
	{
		SPC_ST_RESET = 3'h1,
		SPC_ST_STRAP = 3'h2,
		SPC_ST_SERIAL = 3'h4
	} spc_state_t;
endpackage : spc_pkg

// ===== verilog/spc_lane_mux.sv
// Purpose: One 4:1 lane selector with registered output
// Assumes: Select is one-hot
// Notes: Used for high-speed and auxiliary lanes alike
`timescale 1ns/10ps
module spc_lane_mux
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [3:0] i_sel_onehot,
	input wire logic i_gate,
	input wire logic [3:0] i_src,
	output logic o_lane
);
	logic lane_reg;
	logic lane_next;
	// Gate low parks the lane quiet instead of passing a source
	assign lane_next = i_gate & |(i_sel_onehot & i_src);
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			lane_reg <= 1'b0;
		else
			lane_reg <= lane_next;
	end
	assign o_lane = lane_reg;
endmodule : spc_lane_mux

// ===== verilog/spc_strap_loader.sv
// Purpose: Decode parallel configuration straps into switch settings
// Assumes: Serial interface logic reports its first access as a pulse
// Notes: Straps are captured once, at the first edge after reset release
`timescale 1ns/10ps
module spc_strap_loader
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_link_enable_strap,
	input wire logic [1:0] i_source_select_strap,
	input wire logic i_equalizer_level_strap,
	input wire logic [1:0] i_preemphasis_level_strap,
	input wire logic i_output_termination_strap,
	input wire logic i_output_current_strap,
	input wire logic i_serial_access,
	input wire logic [3:0] i_lane_a,
	input wire logic [3:0] i_lane_b,
	input wire logic [3:0] i_lane_c,
	input wire logic [3:0] i_lane_d,
	input wire logic [3:0] i_aux_a,
	input wire logic [3:0] i_aux_b,
	input wire logic [3:0] i_aux_c,
	input wire logic [3:0] i_aux_d,
	output logic [3:0] o_lane_out,
	output logic [3:0] o_aux_com,
	output logic o_strap_mode,
	output logic o_standby,
	output logic [7:0] o_link_mode_control,
	output logic [7:0] o_side_channel_mode_control,
	output logic [7:0] o_input_termination_control,
	output logic [7:0] o_input_equalizer_control,
	output logic [7:0] o_output_driver_settings
);
	// ****************************************************************
	// Capture control
	// ****************************************************************
	spc_pkg::spc_state_t state_reg;
	spc_pkg::spc_state_t state_next;
	logic load;
	logic en_reg;
	logic [1:0] sel_reg;
	logic eq_reg;
	logic [1:0] pe_reg;
	logic oto_reg;
	logic ocl_reg;
	logic [3:0] sel_onehot;
	logic strap_live;
	logic link_on;
	logic [7:0] link_mode_next;
	logic [7:0] aux_mode_next;
	logic [7:0] driver_next;
	logic [7:0] link_mode_reg;
	logic [7:0] aux_mode_reg;
	logic [7:0] eq_ctl_reg;
	logic [7:0] driver_reg;
	logic standby_reg;
	logic strap_mode_reg;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			spc_pkg::SPC_ST_RESET: state_next = i_serial_access ? spc_pkg::SPC_ST_SERIAL
				: spc_pkg::SPC_ST_STRAP;
			spc_pkg::SPC_ST_STRAP: if (i_serial_access) state_next = spc_pkg::SPC_ST_SERIAL;
			spc_pkg::SPC_ST_SERIAL: state_next = spc_pkg::SPC_ST_SERIAL;
			default: state_next = spc_pkg::SPC_ST_RESET;
		endcase
	end

	// Sample once after release; later strap moves need a reset to take effect
	assign load = (state_reg == spc_pkg::SPC_ST_RESET) && !i_serial_access;

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			state_reg <= spc_pkg::SPC_ST_RESET;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			en_reg <= 1'b0;
			sel_reg <= spc_pkg::SPC_SRC_A;
			eq_reg <= 1'b0;
			pe_reg <= 2'h0;
			oto_reg <= 1'b0;
			ocl_reg <= 1'b0;
		end
		else if (load)
		begin
			en_reg <= i_link_enable_strap;
			sel_reg <= i_source_select_strap;
			eq_reg <= i_equalizer_level_strap;
			pe_reg <= i_preemphasis_level_strap;
			oto_reg <= i_output_termination_strap;
			ocl_reg <= i_output_current_strap;
		end
	end

	// ****************************************************************
	// Decode
	// ****************************************************************
	assign sel_onehot = (sel_reg == spc_pkg::SPC_SRC_A) ? spc_pkg::SPC_ONEHOT_A
		: (sel_reg == spc_pkg::SPC_SRC_B) ? spc_pkg::SPC_ONEHOT_B
		: (sel_reg == spc_pkg::SPC_SRC_C) ? spc_pkg::SPC_ONEHOT_C
		: spc_pkg::SPC_ONEHOT_D;
	// Strap mode starts once the images hold captured values, so nothing shows reset zeros
	assign strap_live = (state_reg == spc_pkg::SPC_ST_STRAP)
		&& (state_next == spc_pkg::SPC_ST_STRAP);
	// Lanes stay quiet until straps are captured and while serial control owns the switch
	assign link_on = en_reg && strap_live;
	assign aux_mode_next = spc_pkg::SPC_AUX_MODE_FIXED | {6'h00, sel_reg};

	always_comb
	begin
		link_mode_next = spc_pkg::SPC_REG_ZERO;
		link_mode_next[spc_pkg::SPC_ENABLE_BIT] = en_reg;
		link_mode_next[spc_pkg::SPC_SEL_LSB +: 2] = sel_reg;
	end

	always_comb
	begin
		driver_next = spc_pkg::SPC_REG_ZERO;
		driver_next[spc_pkg::SPC_PE_LSB +: 2] = pe_reg;
		driver_next[spc_pkg::SPC_OTO_BIT] = oto_reg;
		driver_next[spc_pkg::SPC_OCL_BIT] = ocl_reg;
	end

	// ****************************************************************
	// Register images
	// ****************************************************************
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			link_mode_reg <= spc_pkg::SPC_REG_ZERO;
			aux_mode_reg <= spc_pkg::SPC_REG_ZERO;
		end
		else
		begin
			link_mode_reg <= link_mode_next;
			aux_mode_reg <= aux_mode_next;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			eq_ctl_reg <= spc_pkg::SPC_REG_ZERO;
			driver_reg <= spc_pkg::SPC_REG_ZERO;
		end
		else
		begin
			// Equalizer strap fans out to every lane bit of the equalizer word
			eq_ctl_reg <= eq_reg ? spc_pkg::SPC_REG_ONES : spc_pkg::SPC_REG_ZERO;
			driver_reg <= driver_next;
		end
	end

	// ****************************************************************
	// Status
	// ****************************************************************
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			standby_reg <= 1'b1;
			strap_mode_reg <= 1'b0;
		end
		else
		begin
			standby_reg <= !link_on;
			strap_mode_reg <= strap_live;
		end
	end

	// ****************************************************************
	// Lane routing
	// ****************************************************************
	genvar n;
	generate
		for (n = 0; n < spc_pkg::SPC_LANES; n++)
		begin : g_lane
			spc_lane_mux u_hs
			(
				.i_clock(i_clock),
				.i_rstn(i_rstn),
				.i_sel_onehot(sel_onehot),
				.i_gate(link_on),
				.i_src({i_lane_d[n], i_lane_c[n], i_lane_b[n], i_lane_a[n]}),
				.o_lane(o_lane_out[n])
			);
			spc_lane_mux u_aux
			(
				.i_clock(i_clock),
				.i_rstn(i_rstn),
				.i_sel_onehot(sel_onehot),
				.i_gate(strap_live),
				.i_src({i_aux_d[n], i_aux_c[n], i_aux_b[n], i_aux_a[n]}),
				.o_lane(o_aux_com[n])
			);
		end
	endgenerate

	assign o_strap_mode = strap_mode_reg;
	assign o_standby = standby_reg;
	assign o_link_mode_control = link_mode_reg;
	assign o_side_channel_mode_control = aux_mode_reg;
	// Input terminations are never switched on from straps
	assign o_input_termination_control = spc_pkg::SPC_REG_ZERO;
	assign o_input_equalizer_control = eq_ctl_reg;
	assign o_output_driver_settings = driver_reg;
endmodule : spc_strap_loader

// ===== verif/spc_board_straps.sv
// Purpose: Board straps and reset source for the strap loader
// Assumes: Straps are static levels that move only while the bench asks
// Notes: A request re-pulses reset, as a new source select needs
`timescale 1ns/10ps
module spc_board_straps
(
	input wire logic i_clock,
	input wire logic [7:0] i_cfg,
	input wire logic i_pulse,
	output logic [7:0] o_straps,
	output logic o_rstn
);
	// ******
	// Reset pulse
	// ******
	int cnt = 12;
	assign o_straps = i_cfg;
	assign o_rstn = (cnt == 0);
	always @(posedge i_clock)
	begin
		if (i_pulse)
			cnt <= 2;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
endmodule : spc_board_straps

// ===== verif/spc_strap_loader_asserts.sv
// Purpose: Port checks for the strap loader
// Assumes: One clock, asynchronous active-low reset
// Notes: Lane checks skip the first strap-mode cycle
`timescale 1ns/10ps
module spc_strap_loader_asserts
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_serial_access,
	input wire logic [3:0] i_lane_a,
	input wire logic [3:0] i_lane_b,
	input wire logic [3:0] i_lane_c,
	input wire logic [3:0] i_lane_d,
	input wire logic [3:0] i_aux_a,
	input wire logic [3:0] i_aux_b,
	input wire logic [3:0] i_aux_c,
	input wire logic [3:0] i_aux_d,
	input wire logic [3:0] o_lane_out,
	input wire logic [3:0] o_aux_com,
	input wire logic o_strap_mode,
	input wire logic o_standby,
	input wire logic [7:0] o_link_mode_control,
	input wire logic [7:0] o_side_channel_mode_control,
	input wire logic [7:0] o_input_termination_control,
	input wire logic [7:0] o_input_equalizer_control,
	input wire logic [7:0] o_output_driver_settings
);
	// ******
	// Checks
	// ******
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	wire logic [15:0] la = {i_lane_d, i_lane_c, i_lane_b, i_lane_a};
	wire logic [15:0] xa = {i_aux_d, i_aux_c, i_aux_b, i_aux_a};
	wire logic [3:0] s4 = {o_link_mode_control[1:0], 2'h0};
	wire logic go = o_strap_mode && !o_standby;
	stby_link_a: assert property (o_strap_mode |-> o_standby == !o_link_mode_control[6])
		else $error("standby disagrees with link enable");
	lanes_off_a: assert property (o_standby && $past(o_standby) |-> o_lane_out == 4'h0)
		else $error("lanes driven in standby");
	lane_route_a: assert property (go && $past(go) |-> o_lane_out == $past(la[s4+:4]))
		else $error("output lanes not from selected source");
	aux_route_a: assert property (o_strap_mode && $past(o_strap_mode) |-> o_aux_com == $past(xa[s4+:4]))
		else $error("aux lines not from selected source");
	aux_mode_a: assert property (o_strap_mode |-> o_side_channel_mode_control == {6'h10, s4[3:2]})
		else $error("aux mode image wrong");
	term_off_a: assert property (o_input_termination_control == 8'h00)
		else $error("input termination enabled");
	eq_all_a: assert property (o_input_equalizer_control inside {8'h00, 8'hFF})
		else $error("equalizer lanes differ");
	hold_cfg_a: assert property (o_strap_mode && $past(o_strap_mode) |-> $stable(o_output_driver_settings) && $stable(o_link_mode_control))
		else $error("settings moved without reset");
	serial_win_a: assert property (i_serial_access |=> !o_strap_mode && o_standby)
		else $error("strap mode kept after serial access");
	cover property (go && $past(go));
	cover property (o_strap_mode && o_standby);
	cover property ($fell(o_strap_mode));
endmodule : spc_strap_loader_asserts
bind spc_strap_loader spc_strap_loader_asserts u_spc_strap_loader_asserts (.*);

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the strap loader
// Assumes: Board model owns reset and straps
// Notes: Notes queue is matched on each strap-mode change seen while reset is released
`timescale 1ns/10ps
module tb_top;
	// ******
	// Stimulus and checks
	// ******
	logic i_clock = 1'b0;
	logic i_serial_access = 1'b0;
	logic [3:0] i_lane_a = 4'h0, i_lane_b = 4'h0, i_lane_c = 4'h0, i_lane_d = 4'h0;
	logic [3:0] i_aux_a = 4'h0, i_aux_b = 4'h0, i_aux_c = 4'h0, i_aux_d = 4'h0;
	logic [7:0] cfg = 8'h80;
	logic pulse = 1'b0, mq = 1'b0;
	logic [1:0] cs = 2'h0;
	logic [7:0] el = 8'h00;
	logic [32:0] q[$];
	int n_fail = 0, n_compared = 0;
	wire logic i_rstn, i_link_enable_strap, i_equalizer_level_strap;
	wire logic i_output_termination_strap, i_output_current_strap, o_strap_mode, o_standby;
	wire logic [1:0] i_source_select_strap, i_preemphasis_level_strap;
	wire logic [3:0] o_lane_out, o_aux_com;
	wire logic [7:0] o_link_mode_control, o_side_channel_mode_control, o_output_driver_settings;
	wire logic [7:0] o_input_termination_control, o_input_equalizer_control, st;
	wire logic [15:0] la = {i_lane_d, i_lane_c, i_lane_b, i_lane_a};
	wire logic [15:0] xa = {i_aux_d, i_aux_c, i_aux_b, i_aux_a};
	assign {i_link_enable_strap, i_source_select_strap, i_equalizer_level_strap} = st[7:4];
	assign {i_preemphasis_level_strap, i_output_termination_strap, i_output_current_strap} = st[3:0];
	spc_board_straps u_spc_board_straps (.i_clock(i_clock), .i_cfg(cfg), .i_pulse(pulse),
		.o_straps(st), .o_rstn(i_rstn));
	spc_strap_loader u_spc_strap_loader (.*);
	always #4 i_clock = ~i_clock;
	always @(posedge i_clock)
		{i_lane_d, i_lane_c, i_lane_b, i_lane_a, i_aux_d, i_aux_c, i_aux_b, i_aux_a} <= $urandom;
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
		n_compared++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	always @(negedge i_clock)
	begin
		if (o_strap_mode !== mq && i_rstn && q.size() > 0)
		begin
			chk("regs", q.pop_front(), {o_link_mode_control, o_output_driver_settings,
				o_input_equalizer_control, o_input_termination_control, o_standby});
			chk("aux mode", {25'h0, 2'h1, 4'h0, cs}, {25'h0, o_side_channel_mode_control});
		end
		if (o_strap_mode && mq && !o_standby)
			chk("lanes", {25'h0, el}, {25'h0, o_lane_out, o_aux_com});
		mq = o_strap_mode;
		el = {la[cs*4+:4], xa[cs*4+:4]};
	end
	task automatic finish_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// Straps move four cycles before reset asserts, so a missed hold shows up
	task automatic run(input logic [7:0] c, input logic ser);
		cfg <= c;
		repeat (3) @(posedge i_clock);
		q.push_back({1'b0, c[7], 4'h0, c[6:5], 4'h0, c[3:0], {8{c[4]}}, 8'h00, ser | !c[7]});
		cs <= c[6:5];
		pulse <= !ser;
		i_serial_access <= ser;
		@(posedge i_clock);
		pulse <= 1'b0;
		i_serial_access <= 1'b0;
		for (int k = 0; k < 40 && q.size() > 0; k++)
			@(posedge i_clock);
		if (q.size() > 0)
		begin
			n_fail++;
			finish_test();
		end
	endtask : run
	initial
	begin
		void'($urandom(32'hF446));
		// Let the board's power-on reset run its full length first
		repeat (14) @(posedge i_clock);
		for (int i = 0; i < 8; i++)
			run({i[0] | i[2], i[1:0], i[1], ~i[1:0], i[2], ~i[0]}, 1'b0);
		run({1'b1, 2'h3, 1'b1, 2'h0, 1'b1, 1'b0}, 1'b1);
		finish_test();
	end
endmodule : tb_top
